// ===== logic/hscan_timing.sv
// Purpose: Horizontal display enable and blanking windows with indexed registers
// Assumes: Character clock enable from an outside divider, I/O bus in clk_sys domain
//   vert_active and misc_output_register come from logic on clk_sys
// Notes: Blanking is not skewed; only display enable passes the skew line
//   A total written below the running count lets the counter run on to its 9-bit wrap
// Functional notes
// - Scan line period is the line total field plus five character clocks.
// - A zero line total stops display data fetching.
// - Active width end holds the active character count minus one.
// - Display enable starts each line in the vertical active region and ends by width or total.
// - An oversize width end leaves enable on for all but the final character.
// - Blanking starts when the horizontal count reaches blank start.
// - Top bit of blank end register ignores writes and reads as one.
// - Skew bits 6:5 delay both active edges by zero to three character clocks.
// - Blank end is six bits: low five from blank end register, top from sync end bit 7.
// - Blanking ends when the low six count bits match the six-bit blank end.
// - Active width end is read/write but write protected under group zero.
// - Registers are reached by index then data port, pair chosen by emulation mode.
// - Group zero protection covers indices 0 to 7 and is set by retrace end bit 7.
`timescale 1ns/10ps
`default_nettype none
module hscan_timing
  import hscan_pkg::*;
#(
  parameter int SKEW_DEPTH = 3
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Character clock enable and vertical window
  input wire logic char_en,
  input wire logic vert_active,
  // I/O port bus
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_hit,
  // Emulation select from misc output register bit 0
  input wire logic [7:0] misc_output_register,
  // Timing outputs
  output logic disp_en,
  output logic hblank,
  output logic fetch_en,
  output logic [7:0] hcount
);
  typedef struct packed {
    // Register file
    logic [6:0] index;
    logic [7:0] line_total;
    logic [7:0] active_width_end;
    logic [7:0] blank_start;
    logic [6:0] blank_end_low;
    logic [7:0] sync_end;
    logic [7:0] vretrace_end;
    // Line timing
    logic [8:0] count;
    logic active;
    logic blank;
    logic fetch;
    // Bus answer
    logic [7:0] rdata;
    logic hit;
  } hscan_state_t;

  hscan_state_t st_reg;
  hscan_state_t st_next;

  // Decoded bus selects and derived timing fields
  logic skew_out;
  logic colour;
  logic idx_sel;
  logic data_sel;
  logic prot;
  logic last_char;
  logic [5:0] blank_end6;
  logic [8:0] width_end;

  // Period check shared by wrap and enable end
  function automatic logic is_last(input logic [8:0] cnt, input logic [7:0] tot);
    is_last = (cnt == ({1'b0, tot} + LINE_TOTAL_BIAS - 9'h001));
  endfunction

  // One port of the active pair, chosen by emulation mode
  function automatic logic port_is(input logic [15:0] addr, input logic col,
    input logic [15:0] mono, input logic [15:0] clr);
    port_is = (addr == (col ? clr : mono));
  endfunction

  assign colour = misc_output_register[MISC_EMUL_BIT];
  assign idx_sel = port_is(io_addr, colour, PORT_INDEX_MONO, PORT_INDEX_COLOUR);
  assign data_sel = port_is(io_addr, colour, PORT_DATA_MONO, PORT_DATA_COLOUR);

  assign prot = st_reg.vretrace_end[PROTECT_BIT] && (st_reg.index <= IDX_PROTECT_LAST);

  assign blank_end6 = {st_reg.sync_end[SYNC_END_BE5_BIT], st_reg.blank_end_low[BE_LOW_HI:0]};

  // last active character index is the field itself
  assign width_end = {1'b0, st_reg.active_width_end};
  // Last character of the programmed period
  assign last_char = is_last(st_reg.count, st_reg.line_total);

  // Next state: bus access first, then the character step
  always_comb begin
    st_next = st_reg;
    // Answer strobe lasts one cycle; read data holds until the next read
    st_next.hit = 1'b0;
    // Register writes through index and data ports
    if (io_wr && idx_sel) begin
      // Index keeps seven bits; its top bit reads back as zero
      st_next.index = io_wdata[6:0];
    end
    if (io_wr && data_sel) begin
      case (st_reg.index)
        IDX_LINE_TOTAL: if (!prot) st_next.line_total = io_wdata;
        IDX_ACTIVE_WIDTH_END: if (!prot) st_next.active_width_end = io_wdata;
        IDX_BLANK_START: if (!prot) st_next.blank_start = io_wdata;
        IDX_BLANK_END_AND_SKEW: if (!prot) st_next.blank_end_low = io_wdata[6:0];
        // Only bit 7 feeds this block; the rest is kept for readback
        IDX_SYNC_END: if (!prot) st_next.sync_end = io_wdata;
        IDX_VRETRACE_END: begin
          // Outside the protected group, so protection can always be lifted
          st_next.vretrace_end = io_wdata;
        end
        // Unmapped index: write dropped
        default: st_next.index = st_reg.index;
      endcase
    end

    // Reads registered; unmapped index reads zero
    if (io_rd && (idx_sel || data_sel)) begin
      st_next.hit = 1'b1;
      // Index port or data port; both answer in the next cycle
      if (idx_sel) begin
        st_next.rdata = {1'b0, st_reg.index};
      end else begin
        case (st_reg.index)
          IDX_LINE_TOTAL: st_next.rdata = st_reg.line_total;
          IDX_ACTIVE_WIDTH_END: st_next.rdata = st_reg.active_width_end;
          IDX_BLANK_START: st_next.rdata = st_reg.blank_start;
          IDX_BLANK_END_AND_SKEW: st_next.rdata = {1'b1, st_reg.blank_end_low};
          IDX_SYNC_END: st_next.rdata = st_reg.sync_end;
          IDX_VRETRACE_END: st_next.rdata = st_reg.vretrace_end;
          default: st_next.rdata = 8'h00;
        endcase
      end
    end

    st_next.fetch = (st_reg.line_total != 8'h00);

    // A total cut below the running count runs on to the 9-bit wrap
    if (char_en) begin
      // counter wraps after total plus five
      if (last_char) begin
        st_next.count = 9'h000;
        // enable at line start during vertical active
        st_next.active = vert_active;
      end else begin
        st_next.count = st_reg.count + 9'h001;
        // end at width end, or before last character
        if (st_reg.count == width_end || is_last(st_reg.count + 9'h001, st_reg.line_total)) begin
          st_next.active = 1'b0;
        end
      end
      // Start is tested first, so equal start and end leaves blanking on
      // blanking begins at start count
      if (st_next.count[7:0] == st_reg.blank_start && !st_next.count[8]) begin
        st_next.blank = 1'b1;
      end else if (st_next.count[5:0] == blank_end6) begin
        st_next.blank = 1'b0;
      end
    end
  end

  // Reset loads the defaults; undefined fields start at zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.line_total <= LINE_TOTAL_RST;
      st_reg.active_width_end <= ACTIVE_WIDTH_END_RST;
      st_reg.blank_start <= BLANK_START_RST;
      st_reg.blank_end_low <= BLANK_END_RST[6:0];
      st_reg.sync_end <= SYNC_END_RST;
      st_reg.vretrace_end <= VRETRACE_END_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Next enable feeds the chain so code zero lines up with the count
  // skew chain on display enable
  hscan_skew_line #(
    .DEPTH(SKEW_DEPTH)
  ) u_skew (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .adv(char_en),
    .sel(st_reg.blank_end_low[SKEW_HI:SKEW_LO]),
    .din(st_next.active),
    .dout(skew_out)
  );

  // Outputs come straight from registers
  assign disp_en = skew_out;
  assign hblank = st_reg.blank;
  assign fetch_en = st_reg.fetch;
  assign hcount = st_reg.count[7:0];
  assign io_rdata = st_reg.rdata;
  assign io_hit = st_reg.hit;
endmodule
`default_nettype wire

// ===== inc/hscan_pkg.sv
// Purpose: Shared constants for the horizontal scan timing block
// Assumes: Byte-wide indexed register access, one character clock enable
// Notes: Offsets are controller register indices
`default_nettype none
package hscan_pkg;
  // Register indices
  localparam logic [6:0] IDX_LINE_TOTAL = 7'h00;
  localparam logic [6:0] IDX_ACTIVE_WIDTH_END = 7'h01;
  localparam logic [6:0] IDX_BLANK_START = 7'h02;
  localparam logic [6:0] IDX_BLANK_END_AND_SKEW = 7'h03;
  localparam logic [6:0] IDX_SYNC_END = 7'h05;
  localparam logic [6:0] IDX_VRETRACE_END = 7'h11;
  localparam logic [6:0] IDX_PROTECT_LAST = 7'h07;
  // Reset values
  localparam logic [7:0] LINE_TOTAL_RST = 8'h00;
  localparam logic [7:0] ACTIVE_WIDTH_END_RST = 8'h00;
  localparam logic [7:0] BLANK_START_RST = 8'h00;
  localparam logic [7:0] BLANK_END_RST = 8'h80;
  localparam logic [7:0] SYNC_END_RST = 8'h00;
  localparam logic [7:0] VRETRACE_END_RST = 8'h00;
  // Field positions
  localparam int BE_RSVD_BIT = 7;
  localparam int SKEW_HI = 6;
  localparam int SKEW_LO = 5;
  localparam int BE_LOW_HI = 4;
  localparam int SYNC_END_BE5_BIT = 7;
  localparam int PROTECT_BIT = 7;
  localparam int MISC_EMUL_BIT = 0;
  // Timing
  localparam logic [8:0] LINE_TOTAL_BIAS = 9'h005;
  localparam logic [7:0] ACTIVE_END_BIAS = 8'h01;
  // I/O ports
  localparam logic [15:0] PORT_INDEX_MONO = 16'h03b4;
  localparam logic [15:0] PORT_DATA_MONO = 16'h03b5;
  localparam logic [15:0] PORT_INDEX_COLOUR = 16'h03d4;
  localparam logic [15:0] PORT_DATA_COLOUR = 16'h03d5;
endpackage
`default_nettype wire

// ===== logic/hscan_skew_line.sv
// Purpose: Selectable delay of display enable by 0..3 character clocks
// Assumes: Advance enable is the character clock pulse
// Notes: Output comes straight from a flop
`timescale 1ns/10ps
`default_nettype none
module hscan_skew_line #(
  parameter int DEPTH = 3
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Character step and data
  input wire logic adv,
  input wire logic [1:0] sel,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic [DEPTH-1:0] chain;
    logic out;
  } skew_state_t;
  skew_state_t st_reg;
  skew_state_t st_next;
  assign dout = st_reg.out;
  // Shift chain; tap chosen by code, zero code passes input through one flop
  always_comb begin
    st_next = st_reg;
    if (adv) begin
      st_next.chain = {st_reg.chain[DEPTH-2:0], din};
      if (sel == 2'h0) begin
        st_next.out = din;
      end else begin
        st_next.out = st_reg.chain[sel - 2'h1];
      end
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/hscan_chk.sv
// Purpose: Port assertions for hscan_timing
// Assumes: Character steps come from char_en
// Notes: Register contents are not shadowed here
`timescale 1ns/10ps
`default_nettype none
module hscan_chk
  import hscan_pkg::*;
(
  // Watched ports
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic char_en,
  input wire logic io_rd,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] misc_output_register,
  input wire logic [7:0] io_rdata,
  input wire logic io_hit,
  input wire logic disp_en,
  input wire logic hblank,
  input wire logic [7:0] hcount
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Active port pair follows the emulation bit
  logic [15:0] base;
  assign base = misc_output_register[0] ? PORT_INDEX_COLOUR : PORT_INDEX_MONO;
  sequence rd_ok; io_rd && io_addr[15:1] == base[15:1]; endsequence
  sequence rd_bad; io_rd && io_addr[15:1] != base[15:1]; endsequence
  chk_hit_answer: assert property (rd_ok |=> io_hit)
    else $error("no read answer");
  chk_hit_stray: assert property (rd_bad |=> !io_hit)
    else $error("stray port answered");
  chk_hit_cause: assert property (io_hit |-> $past(io_rd))
    else $error("answer without read");
  chk_rdata_hold: assert property (!io_rd |=> $stable(io_rdata))
    else $error("read data moved");
  chk_count_hold: assert property (!char_en |=> $stable(hcount))
    else $error("count moved without step");
  chk_count_step: assert property (char_en |=> hcount == $past(hcount) + 8'h01 || hcount == 8'h00)
    else $error("count step wrong");
  chk_de_step: assert property ($changed(disp_en) |-> $past(char_en))
    else $error("enable moved off step");
  chk_blank_step: assert property ($changed(hblank) |-> $past(char_en))
    else $error("blank moved off step");
endmodule
bind hscan_timing hscan_chk chk (.clk_sys(clk_sys), .nrst(nrst), .char_en(char_en),
  .io_rd(io_rd), .io_addr(io_addr), .misc_output_register(misc_output_register),
  .io_rdata(io_rdata), .io_hit(io_hit), .disp_en(disp_en), .hblank(hblank), .hcount(hcount));
`default_nettype wire

// ===== testbench/hscan_timing_tb.sv
// Purpose: Self-checking bench for hscan_timing
// Assumes: char_en every second clock
// Notes: Line figures are counted in character steps
`timescale 1ns/10ps
`default_nettype none
module hscan_timing_tb;
  import hscan_pkg::*;
  logic clk_sys = 1'b0, nrst = 1'b0, char_en = 1'b0, vert_active = 1'b1;
  logic io_wr = 1'b0, io_rd = 1'b0, io_hit, disp_en, hblank, fetch_en;
  logic [15:0] io_addr = 16'h0000, lfsr = 16'h1e9f, base;
  logic [7:0] io_wdata = 8'h00, misc_output_register = 8'h00, io_rdata, hcount, d;
  int error_cnt = 0, tests_run = 0, per, de, hb, de_at, hb_at, w, bs;
  hscan_timing uut (.clk_sys(clk_sys), .nrst(nrst), .char_en(char_en),
    .vert_active(vert_active), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit),
    .misc_output_register(misc_output_register), .disp_en(disp_en), .hblank(hblank),
    .fetch_en(fetch_en), .hcount(hcount));
  always #12.5 clk_sys = ~clk_sys;
  // Character step on every second clock
  always @(posedge clk_sys) char_en <= ~char_en;
  assign base = misc_output_register[0] ? PORT_INDEX_COLOUR : PORT_INDEX_MONO;
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Expected readback: the blank end register's top bit always reads one
  function automatic logic [7:0] exp_rd(input logic [6:0] idx, input logic [7:0] v);
    return (idx == IDX_BLANK_END_AND_SKEW) ? {1'b1, v[6:0]} : v;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  // One port cycle; a missing answer reads as ee
  task automatic io(input logic [15:0] a, input logic wr, input logic [7:0] wd);
    @(posedge clk_sys);
    io_addr <= a;
    io_wr <= wr;
    io_rd <= !wr;
    io_wdata <= wd;
    @(posedge clk_sys);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    @(negedge clk_sys);
    d = io_hit ? io_rdata : 8'hee;
  endtask
  task automatic reg_io(input logic [6:0] idx, input logic wr, input logic [7:0] wd);
    io(base, 1'b1, {1'b0, idx});
    io(base + 16'h0001, wr, wd);
  endtask
  // Sample once per step from one wrap to the next
  task automatic line();
    @(negedge clk_sys);
    while (hcount !== 8'h00 || char_en) @(negedge clk_sys);
    per = 0;
    de = 0;
    hb = 0;
    de_at = -1;
    hb_at = -1;
    do begin
      per++;
      de += disp_en;
      hb += hblank;
      if (disp_en && de_at < 0) de_at = hcount;
      if (hblank && hb_at < 0) hb_at = hcount;
      repeat (2) @(negedge clk_sys);
    end while (hcount !== 8'h00);
  endtask
  task automatic results();
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_sys);
    error_cnt++;
    results();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    reg_io(IDX_LINE_TOTAL, 1'b0, 8'h00);
    check(d, 8'h00);
    check(fetch_en, 1'b0);
    reg_io(IDX_BLANK_END_AND_SKEW, 1'b0, 8'h00);
    check(d, 8'h80);
    // Random readback in both emulation modes
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_sys);
      misc_output_register <= {7'h00, m[0]};
      @(negedge clk_sys);
      for (int i = 0; i < 4; i++) begin
        lfsr = step(lfsr);
        reg_io(i[6:0], 1'b1, lfsr[7:0]);
        reg_io(i[6:0], 1'b0, 8'h00);
        check(d, exp_rd(i[6:0], lfsr[7:0]));
      end
    end
    @(posedge clk_sys);
    misc_output_register <= 8'h00;
    @(negedge clk_sys);
    io(PORT_DATA_COLOUR, 1'b0, 8'h00);
    check(d, 8'hee);
    reg_io(7'h20, 1'b0, 8'h00);
    check(d, 8'h00);
    io(base, 1'b0, 8'h00);
    check(d, 8'h20);
    // Protected write must leave the old width
    reg_io(IDX_ACTIVE_WIDTH_END, 1'b1, 8'h5a);
    reg_io(IDX_VRETRACE_END, 1'b1, 8'h80);
    reg_io(IDX_VRETRACE_END, 1'b0, 8'h00);
    check(d, 8'h80);
    reg_io(IDX_ACTIVE_WIDTH_END, 1'b1, 8'ha5);
    reg_io(IDX_ACTIVE_WIDTH_END, 1'b0, 8'h00);
    check(d, 8'h5a);
    reg_io(IDX_VRETRACE_END, 1'b1, 8'h00);
    reg_io(IDX_SYNC_END, 1'b1, 8'h00);
    reg_io(IDX_LINE_TOTAL, 1'b1, 8'h0c);
    // Every skew code, random width, blank length 3
    for (int s = 0; s < 4; s++) begin
      lfsr = step(lfsr);
      w = 2 + lfsr[2:0] % 6;
      bs = w + 2;
      reg_io(IDX_ACTIVE_WIDTH_END, 1'b1, w[7:0]);
      reg_io(IDX_BLANK_START, 1'b1, bs[7:0]);
      reg_io(IDX_BLANK_END_AND_SKEW, 1'b1, {1'b0, s[1:0], bs[4:0] + 5'h03});
      line();
      line();
      check(fetch_en, 1'b1);
      check(per, 17);
      check(de, w + 1);
      check(de_at, s);
      check(hb, 3);
      check(hb_at, bs);
    end
    // Top blank end bit puts the end out of reach
    reg_io(IDX_SYNC_END, 1'b1, 8'h80);
    reg_io(IDX_SYNC_END, 1'b0, 8'h00);
    check(d, 8'h80);
    line();
    line();
    check(hb, 17);
    reg_io(IDX_ACTIVE_WIDTH_END, 1'b1, 8'hff);
    reg_io(IDX_BLANK_END_AND_SKEW, 1'b1, 8'h00);
    line();
    line();
    check(de, 16);
    @(posedge clk_sys);
    vert_active <= 1'b0;
    line();
    line();
    check(de, 0);
    reg_io(IDX_LINE_TOTAL, 1'b1, 8'h00);
    repeat (4) @(negedge clk_sys);
    check(fetch_en, 1'b0);
    results();
  end
endmodule
`default_nettype wire
